// ---- rtc_config_regs.sv ----
/*
 * rtc_config_regs: configuration register bank of a self-powered
 * pushbutton transmitter: source address, custom channels, input
 * status substitution and mesh channel selection with learn-button
 * stepping.
 * Assumes: all inputs synchronous to ref_clk; one-cycle strobes from
 * a register master that never issues read and write together.
 */
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - six-byte source address is fixed prefix above the 32-bit factory value
// - factory value always carries the family nibble in its top byte
// - custom channel registers reset to 0x25, 0x26, 0x27 and drive custom channels
// - custom channel number in bits 6:0, bit 7 reserved
// - substitution used only when encoding select is 1
// - substituted status byte chosen from eight registers by input index
// - both inputs open with harvester actuated gives index zero
// - substitution value 0xff suppresses the data telegram
// - mesh channel code 0..15 maps to channel 11..26
// - mesh configuration resets to 0x20, channel 11
// - step mode: none, primary only, all channels (default)
// - stepping starts from the channel in the transmit channel field
// - encoding select is bit 6 of the short-range configuration
module rtc_config_regs #(
    parameter logic [27:0] FACTORY_LOW = 28'h0000001 // arbitrary value
) (
    input wire logic ref_clk,                   // 250 MHz clock
    input wire logic sys_rst,                   // async reset, high
    input wire logic [7:0] reg_addr,            // register byte address
    input wire logic [7:0] reg_wdata,           // write data
    input wire logic reg_wr,                    // write strobe
    input wire logic reg_rd,                    // read strobe
    output logic [7:0] reg_rdata,               // read data, cycle after strobe
    input wire logic learn_button,              // learn press, one-cycle pulse
    input wire logic tel_req,                   // data telegram request pulse
    input wire logic [2:0] tel_index,           // input condition index
    input wire logic [7:0] tel_default_status,  // standard status byte
    output rtc_pkg::rtc_tel_type tel_out,       // telegram outcome
    output logic [47:0] static_source_addr,     // six-byte source address
    output logic [6:0] custom_channel_one,      // first custom channel
    output logic [6:0] custom_channel_two,      // second custom channel
    output logic [6:0] custom_channel_three,    // third custom channel
    output logic custom_enc_enable,             // substitution enabled
    output logic [4:0] mesh_channel_number,     // live mesh channel 11..26
    output rtc_pkg::rtc_step_type button_channel_step_mode // step mode
);

    // ************************************************************
    // storage
    // ************************************************************
    logic [6:0] ch_one_ff;
    logic [6:0] ch_two_ff;
    logic [6:0] ch_three_ff;
    logic [7:0] sr_cfg_ff;
    logic [7:0] sub_ff [0:7];
    logic [5:0] mesh_cfg_ff;
    logic [3:0] cur_code_ff;
    logic [7:0] rdata_ff;
    rtc_pkg::rtc_tel_type tel_ff;
    logic [47:0] src_ff;
    logic [4:0] chan_num_ff;

    // ************************************************************
    // address decode
    // ************************************************************
    wire logic [31:0] factory_source_address;
    wire logic wr_ch_one;
    wire logic wr_ch_two;
    wire logic wr_ch_three;
    wire logic wr_sr_cfg;
    wire logic wr_sub;
    wire logic wr_mesh;
    wire logic [2:0] sub_sel;

    // family nibble is forced so the value can never leave its range
    assign factory_source_address = {rtc_pkg::FAMILY_NIBBLE, FACTORY_LOW};
    assign wr_ch_one = reg_wr && (reg_addr == rtc_pkg::ADDR_CH_ONE);
    assign wr_ch_two = reg_wr && (reg_addr == rtc_pkg::ADDR_CH_TWO);
    assign wr_ch_three = reg_wr && (reg_addr == rtc_pkg::ADDR_CH_THREE);
    assign wr_sr_cfg = reg_wr && (reg_addr == rtc_pkg::ADDR_SR_TX_CFG);
    assign wr_sub = reg_wr && (reg_addr >= rtc_pkg::ADDR_SUB_BASE)
        && (reg_addr <= rtc_pkg::ADDR_SUB_LAST);
    assign wr_mesh = reg_wr && (reg_addr == rtc_pkg::ADDR_MESH_CFG);
    assign sub_sel = reg_addr[2:0];

    // ************************************************************
    // read multiplexer
    // ************************************************************
    logic [7:0] nxt_rdata;

    // reserved bits read as zero; unmapped addresses read as zero
    always_comb begin
        nxt_rdata = 8'h00;
        if (reg_addr <= rtc_pkg::ADDR_SRC_B3) begin
            nxt_rdata = factory_source_address[{reg_addr[1:0], 3'h0} +: 8];
        end else if (reg_addr == rtc_pkg::ADDR_CH_ONE) begin
            nxt_rdata = {1'b0, ch_one_ff};
        end else if (reg_addr == rtc_pkg::ADDR_CH_TWO) begin
            nxt_rdata = {1'b0, ch_two_ff};
        end else if (reg_addr == rtc_pkg::ADDR_CH_THREE) begin
            nxt_rdata = {1'b0, ch_three_ff};
        end else if (reg_addr == rtc_pkg::ADDR_SR_TX_CFG) begin
            nxt_rdata = {1'b0, sr_cfg_ff[6:0]};
        end else if (wr_sub || (reg_addr >= rtc_pkg::ADDR_SUB_BASE
                && reg_addr <= rtc_pkg::ADDR_SUB_LAST)) begin
            nxt_rdata = sub_ff[sub_sel];
        end else if (reg_addr == rtc_pkg::ADDR_MESH_CFG) begin
            nxt_rdata = {2'b00, mesh_cfg_ff};
        end else if (reg_addr == rtc_pkg::ADDR_MESH_CUR) begin
            nxt_rdata = {4'h0, cur_code_ff};
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= reg_rd ? nxt_rdata : 8'h00;
        end
    end

    // ************************************************************
    // custom channel and short-range configuration registers
    // ************************************************************
    // bit 7 of each channel write is dropped: it is reserved
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ch_one_ff <= rtc_pkg::RST_CH_ONE;
            ch_two_ff <= rtc_pkg::RST_CH_TWO;
            ch_three_ff <= rtc_pkg::RST_CH_THREE;
            sr_cfg_ff <= rtc_pkg::RST_SR_TX_CFG;
        end else begin
            if (wr_ch_one) begin
                ch_one_ff <= reg_wdata[6:0];
            end
            if (wr_ch_two) begin
                ch_two_ff <= reg_wdata[6:0];
            end
            if (wr_ch_three) begin
                ch_three_ff <= reg_wdata[6:0];
            end
            if (wr_sr_cfg) begin
                sr_cfg_ff <= {1'b0, reg_wdata[6:0]};
            end
        end
    end

    // ************************************************************
    // input-status substitution registers
    // ************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_sub
            // one register per input condition index
            always_ff @(posedge ref_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    sub_ff[gi] <= rtc_pkg::RST_SUB;
                end else if (wr_sub && (sub_sel == 3'(gi))) begin
                    sub_ff[gi] <= reg_wdata;
                end
            end
        end
    endgenerate

    // ************************************************************
    // telegram input-status selection
    // ************************************************************
    wire logic enc_sel;
    wire logic [7:0] sub_value;
    rtc_pkg::rtc_tel_type nxt_tel;

    assign enc_sel = sr_cfg_ff[rtc_pkg::SR_ENC_SEL_BIT];
    // index 0 is the open-inputs harvester case and reads register 0
    assign sub_value = sub_ff[tel_index];

    // a 0xff substitution drops the telegram instead of sending it
    always_comb begin
        nxt_tel = '0;
        if (tel_req) begin
            if (!enc_sel) begin
                nxt_tel.send = 1'b1;
                nxt_tel.status = tel_default_status;
            end else if (sub_value == rtc_pkg::SUPPRESS_VALUE) begin
                nxt_tel.suppress = 1'b1;
            end else begin
                nxt_tel.send = 1'b1;
                nxt_tel.status = sub_value;
            end
        end
    end

    // outcome is a one-cycle pulse the cycle after the request
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tel_ff <= '0;
        end else begin
            tel_ff <= nxt_tel;
        end
    end

    // ************************************************************
    // mesh configuration and learn-button channel stepping
    // ************************************************************
    rtc_pkg::rtc_step_type step_mode;
    logic [3:0] nxt_code;
    logic [3:0] pri_next;

    assign step_mode = rtc_pkg::rtc_step_type'(mesh_cfg_ff[5:4]);

    // next primary code above the current one, wrapping to the first
    always_comb begin
        if (cur_code_ff < rtc_pkg::PRI_B) begin
            pri_next = rtc_pkg::PRI_B;
        end else if (cur_code_ff < rtc_pkg::PRI_C) begin
            pri_next = rtc_pkg::PRI_C;
        end else if (cur_code_ff < rtc_pkg::PRI_D) begin
            pri_next = rtc_pkg::PRI_D;
        end else begin
            pri_next = rtc_pkg::PRI_A;
        end
    end

    // a config write re-seeds the live channel; a press steps it
    always_comb begin
        nxt_code = cur_code_ff;
        if (wr_mesh) begin
            nxt_code = reg_wdata[3:0];
        end else if (learn_button) begin
            unique case (step_mode)
                rtc_pkg::STEP_NONE: nxt_code = cur_code_ff;
                rtc_pkg::STEP_PRIMARY: nxt_code = pri_next;
                rtc_pkg::STEP_ALL: nxt_code = cur_code_ff + 4'h1;
                rtc_pkg::STEP_RSVD: nxt_code = cur_code_ff;
            endcase
        end
    end

    // reserved bits 7:6 are not stored since software keeps them zero
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mesh_cfg_ff <= rtc_pkg::RST_MESH_CFG;
            cur_code_ff <= rtc_pkg::RST_MESH_CFG[3:0];
        end else begin
            if (wr_mesh) begin
                mesh_cfg_ff <= reg_wdata[5:0];
            end
            cur_code_ff <= nxt_code;
        end
    end

    // ************************************************************
    // registered outputs
    // ************************************************************
    // every output is a flop so downstream timing is clean
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            src_ff <= 48'h0;
            chan_num_ff <= rtc_pkg::MESH_CHAN_BASE;
        end else begin
            src_ff <= {rtc_pkg::ADDR_PREFIX, factory_source_address};
            chan_num_ff <= rtc_pkg::MESH_CHAN_BASE + {1'b0, cur_code_ff};
        end
    end

    assign reg_rdata = rdata_ff;
    assign tel_out = tel_ff;
    assign static_source_addr = src_ff;
    assign custom_channel_one = ch_one_ff;
    assign custom_channel_two = ch_two_ff;
    assign custom_channel_three = ch_three_ff;
    assign custom_enc_enable = sr_cfg_ff[rtc_pkg::SR_ENC_SEL_BIT];
    assign mesh_channel_number = chan_num_ff;
    assign button_channel_step_mode = rtc_pkg::rtc_step_type'(mesh_cfg_ff[5:4]);

endmodule

`default_nettype wire

// ---- rtc_pkg.sv ----
/*
 * rtc_pkg: constants and carrier types for the radio transmitter
 * configuration register bank.
 * Assumes: a single 250 MHz clock domain and an 8-bit register port.
 */
package rtc_pkg;

    // ************************************************************
    // register map (byte offsets on the 8-bit register port)
    // ************************************************************
    localparam logic [7:0] ADDR_SRC_B0 = 8'h00; // source address, bits 7:0
    localparam logic [7:0] ADDR_SRC_B3 = 8'h03; // source address, bits 31:24
    localparam logic [7:0] ADDR_CH_ONE = 8'h04;
    localparam logic [7:0] ADDR_CH_TWO = 8'h05;
    localparam logic [7:0] ADDR_CH_THREE = 8'h06;
    localparam logic [7:0] ADDR_SR_TX_CFG = 8'h07;
    localparam logic [7:0] ADDR_SUB_BASE = 8'h08; // eight substitution regs
    localparam logic [7:0] ADDR_SUB_LAST = 8'h0f;
    localparam logic [7:0] ADDR_MESH_CFG = 8'h10;
    localparam logic [7:0] ADDR_MESH_CUR = 8'h11; // live channel code, read only

    // ************************************************************
    // reset values and fixed parts
    // ************************************************************
    localparam logic [6:0] RST_CH_ONE = 7'h25;
    localparam logic [6:0] RST_CH_TWO = 7'h26;
    localparam logic [6:0] RST_CH_THREE = 7'h27;
    localparam logic [7:0] RST_SR_TX_CFG = 8'h00;
    localparam logic [7:0] RST_SUB = 8'h00;
    localparam logic [5:0] RST_MESH_CFG = 6'h20;
    localparam logic [15:0] ADDR_PREFIX = 16'h0000; // arbitrary neutral prefix
    localparam logic [3:0] FAMILY_NIBBLE = 4'h6; // arbitrary family code
    localparam int SUPPRESS_POS = 0;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int SR_ENC_SEL_BIT = 6;
    localparam int MESH_STEP_LSB = 4;
    localparam logic [4:0] MESH_CHAN_BASE = 5'h0b; // code 0 is channel 11
    localparam logic [7:0] SUPPRESS_VALUE = 8'hff;

    // learn-button channel step modes
    typedef enum logic [1:0] {
        STEP_NONE = 2'h0,
        STEP_PRIMARY = 2'h1,
        STEP_ALL = 2'h2,
        STEP_RSVD = 2'h3
    } rtc_step_type;

    // primary channel codes (channels 11, 15, 20, 25)
    localparam logic [3:0] PRI_A = 4'h0;
    localparam logic [3:0] PRI_B = 4'h4;
    localparam logic [3:0] PRI_C = 4'h9;
    localparam logic [3:0] PRI_D = 4'he;

    // outcome of one data telegram request
    typedef struct packed {
        logic send;          // telegram goes out
        logic suppress;      // telegram dropped by a 0xff substitution
        logic [7:0] status;  // input-status byte to transmit
    } rtc_tel_type;

endpackage

// ---- rtc_config_regs_props.sv ----
/* rtc_config_regs_props: port assertions for the config register bank.
   Assumes: one ref_clk domain, sys_rst async active high. */
`timescale 1ns/1ps
`default_nettype none
module rtc_config_regs_props #(
    parameter logic [27:0] FACTORY_LOW = 28'h0000001 // arbitrary value
) (
    input wire logic ref_clk, // clock
    input wire logic sys_rst, // reset
    input wire logic [7:0] reg_addr, // address
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_wr, // write
    input wire logic reg_rd, // read
    input wire logic [7:0] reg_rdata, // read data
    input wire logic learn_button, // press
    input wire logic tel_req, // request
    input wire logic [2:0] tel_index, // index
    input wire logic [7:0] tel_default_status, // default
    input wire rtc_pkg::rtc_tel_type tel_out, // outcome
    input wire logic [47:0] static_source_addr, // address
    input wire logic [6:0] custom_channel_one, // ch one
    input wire logic [6:0] custom_channel_two, // ch two
    input wire logic [6:0] custom_channel_three, // ch three
    input wire logic custom_enc_enable, // enc
    input wire logic [4:0] mesh_channel_number, // mesh
    input wire rtc_pkg::rtc_step_type button_channel_step_mode // mode
);
    // ********************
    // properties
    // ********************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // a mesh write wins over a press in the same cycle
    wire logic mesh_wr = reg_wr && (reg_addr == rtc_pkg::ADDR_MESH_CFG);
    wire logic step_ok = learn_button && !mesh_wr;

    src_addr_a: assert property (!$past(sys_rst) |-> static_source_addr ==
        {rtc_pkg::ADDR_PREFIX, rtc_pkg::FAMILY_NIBBLE, FACTORY_LOW}) else $error("bad source");
    ch_read_a: assert property (reg_rd && reg_addr == rtc_pkg::ADDR_CH_ONE |=>
        reg_rdata == {1'b0, custom_channel_one}) else $error("bad channel read");
    enc_sel_a: assert property (reg_wr && reg_addr == rtc_pkg::ADDR_SR_TX_CFG |=>
        custom_enc_enable == $past(reg_wdata[6])) else $error("bad enc select");
    tel_plain_a: assert property (tel_req && !custom_enc_enable |=>
        tel_out == {2'b10, $past(tel_default_status)}) else $error("bad plain telegram");
    tel_idle_a: assert property (!$past(tel_req) |-> tel_out == 10'h000)
        else $error("telegram without request");
    tel_drop_a: assert property (tel_out.suppress |-> !tel_out.send &&
        tel_out.status == 8'h00 && $past(custom_enc_enable)) else $error("bad suppress");
    mesh_seed_a: assert property (mesh_wr |-> ##2 mesh_channel_number ==
        5'h0b + $past(reg_wdata[3:0], 2)) else $error("bad mesh reseed");
    step_mode_a: assert property (mesh_wr |=>
        button_channel_step_mode == $past(reg_wdata[5:4])) else $error("bad step mode");
    step_hold_a: assert property (step_ok && button_channel_step_mode[0] ==
        button_channel_step_mode[1] |-> ##2 $stable(mesh_channel_number)) else $error("moved");
    step_all_a: assert property (step_ok && button_channel_step_mode == rtc_pkg::STEP_ALL
        |-> ##2 mesh_channel_number == ($past(mesh_channel_number) == 5'h1a ? 5'h0b :
        $past(mesh_channel_number) + 5'h01)) else $error("bad step");
    cover property (tel_out.suppress);
    cover property (step_ok && button_channel_step_mode == rtc_pkg::STEP_PRIMARY);
    cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule

bind rtc_config_regs rtc_config_regs_props #(.FACTORY_LOW(FACTORY_LOW)) u_props (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .learn_button(learn_button),
    .tel_req(tel_req), .tel_index(tel_index), .tel_default_status(tel_default_status),
    .tel_out(tel_out), .static_source_addr(static_source_addr),
    .custom_channel_one(custom_channel_one), .custom_channel_two(custom_channel_two),
    .custom_channel_three(custom_channel_three), .custom_enc_enable(custom_enc_enable),
    .mesh_channel_number(mesh_channel_number),
    .button_channel_step_mode(button_channel_step_mode));
`default_nettype wire

// ---- test_radio_tx_config_regs.sv ----
/* test_radio_tx_config_regs: self-checking bench for rtc_config_regs.
   Assumes: the checker is bound from its own file. */
`timescale 1ns/1ps
`default_nettype none
module test_radio_tx_config_regs;
    localparam logic [27:0] FL = 28'h0a5c3e1; // arbitrary value
    localparam logic [47:0] EXP_SRC = {rtc_pkg::ADDR_PREFIX, rtc_pkg::FAMILY_NIBBLE, FL};
    logic ref_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic learn_button = 1'b0, tel_req = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, tel_default_status = 8'h00;
    logic [2:0] tel_index = 3'h0;
    logic [7:0] reg_rdata, rv, d;
    logic [6:0] ch1, ch2, ch3;
    logic [6:0] chv [3];
    logic [4:0] mesh_num;
    logic enc;
    logic [47:0] src;
    rtc_pkg::rtc_tel_type tel_out;
    rtc_pkg::rtc_step_type step_mode;
    logic [7:0] subs [8];
    logic [3:0] code;
    logic [1:0] mode;
    int err_count = 0, total_checks = 0;

    rtc_config_regs #(.FACTORY_LOW(FL)) uut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .learn_button(learn_button), .tel_req(tel_req),
        .tel_index(tel_index), .tel_default_status(tel_default_status), .tel_out(tel_out),
        .static_source_addr(src), .custom_channel_one(ch1), .custom_channel_two(ch2),
        .custom_channel_three(ch3), .custom_enc_enable(enc),
        .mesh_channel_number(mesh_num), .button_channel_step_mode(step_mode));

    // ********************
    // bus tasks and expectations
    // ********************
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // strobe lasts one cycle, released at the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask
    task automatic pulse(input bit press, input logic [2:0] i, input logic [7:0] v);
        @(posedge ref_clk);
        learn_button <= press;
        tel_req <= !press;
        tel_index <= i;
        tel_default_status <= v;
        @(posedge ref_clk);
        learn_button <= 1'b0;
        tel_req <= 1'b0;
        if (press) @(posedge ref_clk);
        #1;
    endtask
    function automatic logic [3:0] nxt_code(input logic [1:0] m, input logic [3:0] c);
        if (m == 2'h2) return c + 4'h1;
        if (m != 2'h1) return c;
        if (c < 4'h4) return 4'h4;
        if (c < 4'h9) return 4'h9;
        return (c < 4'he) ? 4'he : 4'h0;
    endfunction
    function automatic logic [9:0] exp_tel(input logic e, input logic [7:0] s, input logic [7:0] v);
        if (!e) return {2'b10, v};
        return (s == 8'hff) ? 10'h100 : {2'b10, s};
    endfunction
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // watchdog: the whole sequence needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        report_and_stop();
    end

    // ********************
    // main sequence
    // ********************
    initial begin
        void'($urandom(32'h403c));
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        #1 chk("mesh number", mesh_num, 48'h0b);
        chk("step mode", step_mode, 48'h2);
        chk("source", src, EXP_SRC);
        for (int i = 0; i < 4; i++) begin
            wr(8'(i), 8'h00);
            rd(8'(i));
            chk("source byte", rv, 48'(EXP_SRC[8 * i +: 8]));
        end
        for (int i = 0; i < 3; i++) begin
            rd(8'(rtc_pkg::ADDR_CH_ONE + i));
            chk("channel reset", rv, 48'(8'h25 + i));
            d = 8'($urandom) | 8'h80;
            chv[i] = d[6:0];
            wr(8'(rtc_pkg::ADDR_CH_ONE + i), d);
            rd(8'(rtc_pkg::ADDR_CH_ONE + i));
            chk("channel", rv, 48'(d[6:0]));
        end
        chk("channel ports", {ch1, ch2, ch3}, 48'({chv[0], chv[1], chv[2]}));
        rd(rtc_pkg::ADDR_MESH_CFG);
        chk("mesh reset", rv, 48'h20);
        wr(8'h20, 8'h5a);
        rd(8'h20);
        chk("unmapped", rv, 48'h0);
        for (int i = 0; i < 8; i++) begin
            subs[i] = (i == 3) ? 8'hff : 8'($urandom_range(254, 0));
            wr(8'(rtc_pkg::ADDR_SUB_BASE + i), subs[i]);
        end
        for (int e = 0; e < 2; e++) begin
            wr(rtc_pkg::ADDR_SR_TX_CFG, {1'b0, e[0], 6'($urandom)});
            #1 chk("enc select", enc, 48'(e[0]));
            for (int i = 0; i < 8; i++) begin
                d = 8'($urandom);
                pulse(1'b0, 3'(i), d);
                chk("telegram", tel_out, exp_tel(e[0], subs[i], d));
            end
        end
        for (int k = 0; k < 24; k++) begin
            {mode, code} = 6'($urandom);
            if (k == 0) {mode, code} = 6'h2f;
            if (k == 1) {mode, code} = 6'h1e;
            wr(rtc_pkg::ADDR_MESH_CFG, {2'b00, mode, code});
            @(posedge ref_clk);
            #1 chk("mesh seed", mesh_num, 48'(5'h0b + code));
            for (int p = 0; p < 2; p++) begin
                pulse(1'b1, 3'h0, 8'h00);
                code = nxt_code(mode, code);
                chk("mesh step", mesh_num, 48'(5'h0b + code));
            end
            chk("step mode", step_mode, 48'(mode));
            rd(rtc_pkg::ADDR_MESH_CUR);
            chk("live code", rv, 48'(code));
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
